// >>> common/mer_defines.svh
`ifndef MER_DEFINES_SVH
`define MER_DEFINES_SVH

// register map, byte addresses on the 32-bit bus
`define MER_AW 12
`define MER_OFS_CTRL 12'h000
`define MER_OFS_STAT 12'h004
`define MER_OFS_CNT 12'h008
`define MER_OFS_LAST 12'h00c
`define MER_CTRL_EN_BIT 0
`define MER_CTRL_RST 1'b1
`define MER_RESP_OKAY 2'h0
`define MER_RESP_SLVERR 2'h2

// exception causes
`define MER_EXC_NONE 8'h00
`define MER_EXC_FUNC 8'h01
`define MER_EXC_ADDR 8'h02
`define MER_EXC_FMT 8'h03
`define MER_EXC_RANGE 8'h21
`define MER_EXC_DENIED 8'h22
`define MER_EXC_RDONLY 8'h23
`define MER_EXC_FLAG 8'h80

// reply frame
`define MER_IDX_ADDR 3'h0
`define MER_IDX_FUNC 3'h1
`define MER_IDX_CODE 3'h2
`define MER_IDX_CRCL 3'h3
`define MER_IDX_CRCH 3'h4
`define MER_CRC_INIT 16'hffff
`define MER_CRC_POLY 16'ha001

`endif

// >>> common/mer_pkg.sv
package mer_pkg;

   typedef enum logic {MER_IDLE, MER_SEND} mer_state_t;

   // one decoded query from the front end
   typedef struct packed {
      logic [7:0] slave_addr;
      logic [7:0] func;
      logic bcast;
      logic unsup_func;
      logic bad_addr;
      logic bad_format;
      logic out_of_range;
      logic is_write;
      logic is_enter;
      logic tgt_read_only;
      logic tgt_run_locked;
      logic tgt_soft_locked;
      logic tgt_fixed_io;
      logic tgt_reset_polarity;
      logic tgt_pwd_locked;
      logic not_allowed;
   } mer_query_t;

   // drive core status levels
   typedef struct packed {
      logic running;
      logic undervoltage_state;
      logic trip_uv;
      logic autotune_on;
      logic password_set;
   } mer_drive_t;

   typedef struct packed {
      mer_state_t st;
      mer_query_t q;
      logic [7:0] cause;
      logic [2:0] idx;
      logic [15:0] crc;
      logic qry_ready;
      logic verdict_valid;
      logic verdict_ok;
      logic tx_valid;
      logic [7:0] tx_data;
      logic tx_last;
      logic en;
      logic [15:0] exc_cnt;
      logic [7:0] last_cause;
      logic aw_held;
      logic [11:0] aw_addr;
      logic w_held;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } mer_regs_t;

endpackage : mer_pkg

// >>> hdl/mer_top.sv
`timescale 1ns/1ps
`include "mer_defines.svh"
// Notes on behaviour
// - faulty addressed query gets exception reply
// - never reply to broadcast queries
// - frame: address, function, cause, check
// - reply function equals query function plus 80h
// - cause code names the rejection reason
// - 01h unsupported function, 03h bad format
// - 02h for nonexistent address
// - 21h out-of-range write, register kept
// - 22h when function not permitted now
// - 22h writing run-locked register while running
// - 22h enter command under undervoltage
// - 22h writes during undervoltage trip
// - 22h writing soft-locked register
// - 22h changing fixed terminal assignment
// - 22h changing fault-clear terminal polarity
// - 22h writes while auto-tuning enabled
// - 22h password-locked register while password set
// - 23h writing read-only register or coil
module mer_top
   import mer_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_qry_valid,
   input wire mer_query_t i_qry,
   output logic o_qry_ready,
   input wire mer_drive_t i_drv,
   output logic o_verdict_valid,
   output logic o_verdict_ok,
   output logic [7:0] o_verdict_cause,
   output logic o_tx_valid,
   output logic [7:0] o_tx_data,
   output logic o_tx_last,
   input wire logic i_tx_ready,
   input wire logic i_awvalid,
   input wire logic [11:0] i_awaddr,
   output logic o_awready,
   input wire logic i_wvalid,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   output logic o_wready,
   output logic o_bvalid,
   output logic [1:0] o_bresp,
   input wire logic i_bready,
   input wire logic i_arvalid,
   input wire logic [11:0] i_araddr,
   output logic o_arready,
   output logic o_rvalid,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   input wire logic i_rready
);

   mer_regs_t st_r;
   mer_regs_t st_nxt;

   // one reflected crc-16 step over a byte
   function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                            input logic [7:0] d);
      logic [15:0] x;
      x = c ^ {8'h00, d};
      for (int i = 0; i < 8; i++) begin
         if (x[0]) begin
            x = (x >> 1) ^ `MER_CRC_POLY;
         end else begin
            x = x >> 1;
         end
      end
      return x;
   endfunction : crc_byte

   // cause by priority; 00h means the query is acceptable
   function automatic logic [7:0] cause_of(input mer_query_t q,
                                           input mer_drive_t d);
      logic wr;
      wr = q.is_write;
      if (q.unsup_func) begin
         return `MER_EXC_FUNC;
      end else if (q.bad_addr) begin
         return `MER_EXC_ADDR;
      end else if (q.bad_format) begin
         return `MER_EXC_FMT;
      end else if (wr && q.tgt_read_only) begin
         return `MER_EXC_RDONLY;
      end else if (q.not_allowed) begin
         return `MER_EXC_DENIED;
      end else if (wr && q.tgt_run_locked && d.running) begin
         return `MER_EXC_DENIED;
      end else if (q.is_enter && d.undervoltage_state) begin
         return `MER_EXC_DENIED;
      end else if (wr && d.trip_uv) begin
         return `MER_EXC_DENIED;
      end else if (wr && q.tgt_soft_locked) begin
         return `MER_EXC_DENIED;
      end else if (wr && q.tgt_fixed_io) begin
         return `MER_EXC_DENIED;
      end else if (wr && q.tgt_reset_polarity) begin
         return `MER_EXC_DENIED;
      end else if (wr && d.autotune_on) begin
         return `MER_EXC_DENIED;
      end else if (wr && q.tgt_pwd_locked && d.password_set) begin
         return `MER_EXC_DENIED;
      end else if (wr && q.out_of_range) begin
         return `MER_EXC_RANGE;
      end
      return `MER_EXC_NONE;
   endfunction : cause_of

   logic take;
   logic [7:0] cause_now;
   logic tx_fire;
   logic frame_done;
   logic wr_fire;
   logic cnt_clr;
   logic [15:0] crc_next;

   assign take = i_qry_valid && st_r.qry_ready;
   assign cause_now = cause_of(i_qry, i_drv);
   assign tx_fire = st_r.tx_valid && i_tx_ready;
   assign frame_done = tx_fire && st_r.idx == `MER_IDX_CRCH;
   assign wr_fire = st_r.aw_held && st_r.w_held && !st_r.bvalid;
   assign cnt_clr = wr_fire && st_r.aw_addr == `MER_OFS_CNT;
   assign crc_next = crc_byte(st_r.crc, st_r.tx_data);

   always_comb begin
      st_nxt = st_r;
      st_nxt.verdict_valid = 1'b0;

      // query check and reply framing
      case (st_r.st)
         MER_IDLE: begin
            if (take) begin
               st_nxt.q = i_qry;
               st_nxt.cause = cause_now;
               st_nxt.verdict_valid = 1'b1;
               // write commit for any clean query, whether or not replies are enabled
               st_nxt.verdict_ok = cause_now == `MER_EXC_NONE;
               if (cause_now != `MER_EXC_NONE && !i_qry.bcast &&
                   st_r.en) begin
                  st_nxt.st = MER_SEND;
                  st_nxt.idx = `MER_IDX_ADDR;
                  st_nxt.crc = `MER_CRC_INIT;
                  st_nxt.tx_valid = 1'b1;
                  st_nxt.tx_data = i_qry.slave_addr;
                  st_nxt.tx_last = 1'b0;
               end
            end
         end
         MER_SEND: begin
            if (tx_fire) begin
               st_nxt.idx = 3'(st_r.idx + 3'h1);
               case (st_r.idx)
                  `MER_IDX_ADDR: begin
                     st_nxt.crc = crc_next;
                     st_nxt.tx_data = st_r.q.func | `MER_EXC_FLAG;
                  end
                  `MER_IDX_FUNC: begin
                     st_nxt.crc = crc_next;
                     st_nxt.tx_data = st_r.cause;
                  end
                  `MER_IDX_CODE: begin
                     st_nxt.crc = crc_next;
                     st_nxt.tx_data = crc_next[7:0];
                  end
                  `MER_IDX_CRCL: begin
                     st_nxt.tx_data = st_r.crc[15:8];
                     st_nxt.tx_last = 1'b1;
                  end
                  default: begin
                     st_nxt.st = MER_IDLE;
                     st_nxt.tx_valid = 1'b0;
                     st_nxt.tx_last = 1'b0;
                  end
               endcase
            end
         end
         default: begin
            st_nxt.st = MER_IDLE;
            st_nxt.tx_valid = 1'b0;
         end
      endcase
      st_nxt.qry_ready = st_nxt.st == MER_IDLE;

      // exception counter: a new event with a software clear in one cycle leaves the count at 1
      if (take && cause_now != `MER_EXC_NONE) begin
         st_nxt.last_cause = cause_now;
         st_nxt.exc_cnt = cnt_clr ? 16'h0001 : 16'(st_r.exc_cnt + 16'h0001);
      end else if (cnt_clr) begin
         st_nxt.exc_cnt = 16'h0000;
      end

      // axi4-lite write side
      if (i_awvalid && st_r.awready) begin
         st_nxt.aw_held = 1'b1;
         st_nxt.aw_addr = i_awaddr;
      end
      if (i_wvalid && st_r.wready) begin
         st_nxt.w_held = 1'b1;
         st_nxt.w_data = i_wdata;
         st_nxt.w_strb = i_wstrb;
      end
      if (wr_fire) begin
         st_nxt.aw_held = 1'b0;
         st_nxt.w_held = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = `MER_RESP_OKAY;
         case (st_r.aw_addr)
            `MER_OFS_CTRL: begin
               if (st_r.w_strb[0]) begin
                  st_nxt.en = st_r.w_data[`MER_CTRL_EN_BIT];
               end
            end
            `MER_OFS_STAT, `MER_OFS_CNT, `MER_OFS_LAST: begin
            end
            default: begin
               st_nxt.bresp = `MER_RESP_SLVERR;
            end
         endcase
      end
      if (st_r.bvalid && i_bready) begin
         st_nxt.bvalid = 1'b0;
      end
      st_nxt.awready = !st_nxt.aw_held;
      st_nxt.wready = !st_nxt.w_held;

      // axi4-lite read side
      if (i_arvalid && st_r.arready) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp = `MER_RESP_OKAY;
         st_nxt.rdata = 32'h0000_0000;
         case (i_araddr)
            `MER_OFS_CTRL: st_nxt.rdata[`MER_CTRL_EN_BIT] = st_r.en;
            `MER_OFS_STAT: st_nxt.rdata[0] = st_r.st == MER_SEND;
            `MER_OFS_CNT: st_nxt.rdata[15:0] = st_r.exc_cnt;
            `MER_OFS_LAST: st_nxt.rdata[7:0] = st_r.last_cause;
            default: st_nxt.rresp = `MER_RESP_SLVERR;
         endcase
      end else if (st_r.rvalid && i_rready) begin
         st_nxt.rvalid = 1'b0;
      end
      st_nxt.arready = !st_nxt.rvalid;
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         st_r <= '0;
         st_r.st <= MER_IDLE;
         st_r.qry_ready <= 1'b1;
         st_r.en <= `MER_CTRL_RST;
         st_r.crc <= `MER_CRC_INIT;
         st_r.awready <= 1'b1;
         st_r.wready <= 1'b1;
         st_r.arready <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_qry_ready = st_r.qry_ready;
   assign o_verdict_valid = st_r.verdict_valid;
   assign o_verdict_ok = st_r.verdict_ok;
   assign o_verdict_cause = st_r.cause;
   assign o_tx_valid = st_r.tx_valid;
   assign o_tx_data = st_r.tx_data;
   assign o_tx_last = st_r.tx_last;
   assign o_awready = st_r.awready;
   assign o_wready = st_r.wready;
   assign o_bvalid = st_r.bvalid;
   assign o_bresp = st_r.bresp;
   assign o_arready = st_r.arready;
   assign o_rvalid = st_r.rvalid;
   assign o_rdata = st_r.rdata;
   assign o_rresp = st_r.rresp;

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);

   a_exc_starts:
   assert property (take && cause_now != `MER_EXC_NONE && !i_qry.bcast &&
                    st_r.en |=> o_tx_valid && o_tx_data == $past(
                    i_qry.slave_addr) && !o_qry_ready)
   else $error("exception reply did not start");

   a_bcast_silent:
   assert property (take && i_qry.bcast |=> !o_tx_valid ##1 !o_tx_valid)
   else $error("reply sent for broadcast query");

   a_func_flag:
   assert property (tx_fire && st_r.idx == `MER_IDX_ADDR |=>
                    o_tx_data == {1'b1, st_r.q.func[6:0]})
   else $error("reply function lacks 80h");

   a_cause_byte:
   assert property (tx_fire && st_r.idx == `MER_IDX_FUNC |=>
                    o_tx_data == o_verdict_cause && !o_tx_last)
   else $error("cause byte wrong in frame");

   a_unsup_func:
   assert property (take && i_qry.unsup_func |=>
                    o_verdict_cause == `MER_EXC_FUNC && !o_verdict_ok)
   else $error("unsupported function not 01h");

   a_bad_addr:
   assert property (take && !i_qry.unsup_func && i_qry.bad_addr |=>
                    o_verdict_cause == `MER_EXC_ADDR)
   else $error("missing address not 02h");

   a_run_lock:
   assert property (take && i_qry.is_write && i_qry.tgt_run_locked &&
                    i_drv.running && !i_qry.unsup_func && !i_qry.bad_addr &&
                    !i_qry.bad_format && !i_qry.tgt_read_only |=>
                    o_verdict_cause == `MER_EXC_DENIED)
   else $error("run-locked write not 22h");

   a_read_only:
   assert property (take && i_qry.is_write && i_qry.tgt_read_only &&
                    !i_qry.unsup_func && !i_qry.bad_addr &&
                    !i_qry.bad_format |=> o_verdict_cause == `MER_EXC_RDONLY)
   else $error("read-only write not 23h");

   a_no_commit:
   assert property (o_verdict_valid && o_verdict_cause != `MER_EXC_NONE |->
                    !o_verdict_ok)
   else $error("rejected query allowed to commit");

   a_crc_high:
   assert property (tx_fire && st_r.idx == `MER_IDX_CRCL |=>
                    o_tx_data == $past(st_r.crc[15:8]) && o_tx_last)
   else $error("crc high byte misplaced");

   a_frame_ends:
   assert property (frame_done |=> !o_tx_valid && o_qry_ready)
   else $error("frame did not end after five bytes");

   a_bad_format:
   assert property (take && !i_qry.unsup_func && !i_qry.bad_addr &&
                    i_qry.bad_format |=> o_verdict_cause == `MER_EXC_FMT)
   else $error("bad format not 03h");

   a_range_kept:
   assert property (take && i_qry.is_write && i_qry.out_of_range |=>
                    o_verdict_cause != `MER_EXC_NONE && !o_verdict_ok)
   else $error("out-of-range write allowed to commit");

   a_not_allowed:
   assert property (take && i_qry.not_allowed |=>
                    o_verdict_cause != `MER_EXC_NONE && !o_verdict_ok)
   else $error("forbidden function accepted");

   a_enter_uv:
   assert property (take && i_qry.is_enter && i_drv.undervoltage_state |=>
                    o_verdict_cause != `MER_EXC_NONE && !o_verdict_ok)
   else $error("enter accepted under undervoltage");

   a_trip_write:
   assert property (take && i_qry.is_write && i_drv.trip_uv |=>
                    o_verdict_cause != `MER_EXC_NONE && !o_verdict_ok)
   else $error("write accepted during undervoltage trip");

   a_soft_lock:
   assert property (take && i_qry.is_write && i_qry.tgt_soft_locked |=>
                    o_verdict_cause != `MER_EXC_NONE && !o_verdict_ok)
   else $error("soft-locked write accepted");

   a_autotune_write:
   assert property (take && i_qry.is_write && i_drv.autotune_on |=>
                    o_verdict_cause != `MER_EXC_NONE && !o_verdict_ok)
   else $error("write accepted while auto-tuning");

   c_exc_frame: cover property (frame_done);
   c_clean_query: cover property (o_verdict_valid && o_verdict_ok);
   c_bcast_error: cover property (take && i_qry.bcast &&
                                  cause_now != `MER_EXC_NONE);
   c_stall: cover property (o_tx_valid && !i_tx_ready);

endmodule : mer_top

// >>> dv/mer_master_model.sv
`timescale 1ns/1ps
// far-end sink of the reply stream; can stall every other cycle
module mer_master_model (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_tx_valid,
   input wire logic [7:0] i_tx_data,
   input wire logic i_tx_last,
   input wire logic i_slow,
   output logic o_tx_ready,
   output logic [39:0] o_frame,
   output logic [7:0] o_cnt,
   output logic [7:0] o_nlast
);
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_tx_ready <= 1'b0;
         o_frame <= 40'h0;
         o_cnt <= 8'h0;
         o_nlast <= 8'h0;
      end else begin
         o_tx_ready <= i_slow ? ~o_tx_ready : 1'b1;
         // bytes kept in arrival order, first byte ends up highest
         if (i_tx_valid && o_tx_ready) begin
            o_frame <= {o_frame[31:0], i_tx_data};
            o_cnt <= o_cnt + 8'h1;
            // counts bytes that carry the end-of-frame mark
            if (i_tx_last) begin
               o_nlast <= o_nlast + 8'h1;
            end
         end
      end
   end
endmodule : mer_master_model

// >>> dv/modbus_exception_responder_bench.sv
`timescale 1ns/1ps
`include "mer_defines.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
   error_cnt++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module modbus_exception_responder_bench
   import mer_pkg::*;
;
   logic clk, rst, qv, rdy, slow, awv, wv, bready, arv, rready;
   logic vv, vok, txv, txl, txr, awr, wr, bv, arr, rv;
   logic [7:0] vc, txd, mcnt, nlast;
   logic [39:0] frame;
   logic [11:0] awa, ara;
   logic [31:0] wd, rd;
   logic [1:0] br, rr, resp;
   logic [3:0] ws;
   mer_query_t q;
   mer_drive_t drv;
   int error_cnt, n_compared;
   logic [7:0] fl [7] = '{8'h01, 8'h03, 8'h05, 8'h06, 8'h0f, 8'h10, 8'h17};

   mer_top DUT (.i_clk(clk), .i_sys_rst(rst), .i_qry_valid(qv), .i_qry(q),
      .o_qry_ready(rdy), .i_drv(drv), .o_verdict_valid(vv),
      .o_verdict_ok(vok), .o_verdict_cause(vc), .o_tx_valid(txv),
      .o_tx_data(txd), .o_tx_last(txl), .i_tx_ready(txr),
      .i_awvalid(awv), .i_awaddr(awa), .o_awready(awr), .i_wvalid(wv),
      .i_wdata(wd), .i_wstrb(ws), .o_wready(wr), .o_bvalid(bv),
      .o_bresp(br), .i_bready(bready), .i_arvalid(arv), .i_araddr(ara),
      .o_arready(arr), .o_rvalid(rv), .o_rdata(rd), .o_rresp(rr),
      .i_rready(rready));
   mer_master_model PEER (.i_clk(clk), .i_sys_rst(rst), .i_tx_valid(txv),
      .i_tx_data(txd), .i_tx_last(txl), .i_slow(slow), .o_tx_ready(txr),
      .o_frame(frame), .o_cnt(mcnt), .o_nlast(nlast));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : stop_test

   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      awv <= 1'b1;
      awa <= a;
      wv <= 1'b1;
      wd <= d;
      ws <= 4'hf;
      bready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge clk);
         if (awv && awr) awv <= 1'b0;
         if (wv && wr) wv <= 1'b0;
         if (bv === 1'b1) begin
            resp = br;
            bready <= 1'b0;
            break;
         end
      end
      if (n >= 100) begin
         error_cnt++;
         stop_test();
      end
   endtask : axi_wr

   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d);
      int n;
      @(posedge clk);
      arv <= 1'b1;
      ara <= a;
      rready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge clk);
         if (arv && arr) arv <= 1'b0;
         if (rv === 1'b1) begin
            d = rd;
            resp = rr;
            rready <= 1'b0;
            break;
         end
      end
      if (n >= 100) begin
         error_cnt++;
         stop_test();
      end
   endtask : axi_rd

   function automatic logic [15:0] crc3(input logic [23:0] b);
      logic [15:0] c;
      c = `MER_CRC_INIT;
      for (int i = 0; i < 3; i++) begin
         c = c ^ {8'h00, b[23-8*i -: 8]};
         for (int j = 0; j < 8; j++) begin
            c = c[0] ? ((c >> 1) ^ `MER_CRC_POLY) : (c >> 1);
         end
      end
      return c;
   endfunction : crc3

   task automatic send_q(input mer_query_t qq, input mer_drive_t dd,
                         input logic [7:0] ec, input logic fr);
      int n;
      logic [7:0] c0;
      logic [7:0] l0;
      logic [15:0] cr;
      logic [23:0] hd;
      c0 = mcnt;
      l0 = nlast;
      @(posedge clk);
      qv <= 1'b1;
      q <= qq;
      drv <= dd;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (rdy !== 1'b1 && n < 60);
      qv <= 1'b0;
      if (rdy !== 1'b1) begin
         error_cnt++;
         stop_test();
      end
      @(negedge clk);
      `CHK("verdict valid", 1'b1, vv)
      `CHK("cause", ec, vc)
      `CHK("verdict ok", ec == 8'h00, vok)
      if (fr) begin
         for (n = 0; n < 200 && mcnt !== c0 + 8'd5; n++) begin
            @(negedge clk);
         end
         hd = {qq.slave_addr, qq.func | 8'h80, ec};
         cr = crc3(hd);
         `CHK("reply bytes", c0 + 8'd5, mcnt)
         `CHK("reply func", qq.func | 8'h80, frame[31:24])
         `CHK("reply frame", hd, frame[39:16])
         `CHK("reply check", {cr[7:0], cr[15:8]}, frame[15:0])
         `CHK("last marks", l0 + 8'd1, nlast)
      end else begin
         repeat (10) @(negedge clk);
         `CHK("no reply bytes", c0, mcnt)
         `CHK("no last mark", l0, nlast)
      end
   endtask : send_q

   task automatic t_regs();
      logic [31:0] d;
      axi_rd(`MER_OFS_CTRL, d);
      `CHK("ctrl reset", 32'h1, d)
      axi_rd(`MER_OFS_STAT, d);
      `CHK("idle status", 32'h0, d)
      axi_rd(`MER_OFS_CNT, d);
      `CHK("count reset", 32'h0, d)
      axi_rd(12'h010, d);
      `CHK("unmapped read", `MER_RESP_SLVERR, resp)
      axi_wr(12'h010, 32'h0);
      `CHK("unmapped write", `MER_RESP_SLVERR, resp)
      $display("test regs done");
   endtask : t_regs

   task automatic t_causes();
      mer_query_t qq;
      mer_drive_t dd;
      logic [7:0] ec;
      for (int k = 0; k < 16; k++) begin
         qq = '0;
         dd = '0;
         ec = 8'h22;
         qq.slave_addr = 8'h10 + 8'(k);
         qq.func = fl[k % 7];
         qq.is_write = (k >= 3);
         slow <= k[0];
         case (k)
            0: begin
               qq.unsup_func = 1'b1;
               ec = 8'h01;
            end
            1: begin
               qq.bad_addr = 1'b1;
               ec = 8'h02;
            end
            2: begin
               qq.bad_format = 1'b1;
               ec = 8'h03;
            end
            3: begin
               qq.out_of_range = 1'b1;
               ec = 8'h21;
            end
            4: qq.not_allowed = 1'b1;
            5: begin
               qq.tgt_read_only = 1'b1;
               ec = 8'h23;
            end
            6: begin
               qq.tgt_run_locked = 1'b1;
               dd.running = 1'b1;
            end
            7: begin
               qq.is_enter = 1'b1;
               dd.undervoltage_state = 1'b1;
            end
            8: dd.trip_uv = 1'b1;
            9: qq.tgt_soft_locked = 1'b1;
            10: qq.tgt_fixed_io = 1'b1;
            11: qq.tgt_reset_polarity = 1'b1;
            12: dd.autotune_on = 1'b1;
            13: begin
               qq.tgt_pwd_locked = 1'b1;
               dd.password_set = 1'b1;
            end
            14: begin
               dd.running = 1'b1;
               ec = 8'h00;
            end
            default: begin
               qq.tgt_pwd_locked = 1'b1;
               ec = 8'h00;
            end
         endcase
         send_q(qq, dd, ec, ec != 8'h00);
      end
      $display("test causes done");
   endtask : t_causes

   task automatic t_count_bcast();
      logic [31:0] d;
      mer_query_t qq;
      axi_rd(`MER_OFS_CNT, d);
      `CHK("exception count", 32'd14, d)
      axi_rd(`MER_OFS_LAST, d);
      `CHK("last cause", 32'h22, d)
      qq = '0;
      qq.slave_addr = 8'h00;
      qq.func = 8'h06;
      qq.bcast = 1'b1;
      qq.unsup_func = 1'b1;
      send_q(qq, '0, 8'h01, 1'b0);
      axi_wr(`MER_OFS_CNT, 32'h0);
      axi_rd(`MER_OFS_CNT, d);
      `CHK("count cleared", 32'h0, d)
      $display("test count_bcast done");
   endtask : t_count_bcast

   task automatic t_disable();
      mer_query_t qq;
      qq = '0;
      qq.slave_addr = 8'h05;
      qq.func = 8'h10;
      qq.bad_addr = 1'b1;
      axi_wr(`MER_OFS_CTRL, 32'h0);
      `CHK("ctrl write", `MER_RESP_OKAY, resp)
      send_q(qq, '0, 8'h02, 1'b0);
      axi_wr(`MER_OFS_CTRL, 32'h1);
      send_q(qq, '0, 8'h02, 1'b1);
      $display("test disable done");
   endtask : t_disable

   initial begin
      #1000000;
      error_cnt++;
      stop_test();
   end

   initial begin
      error_cnt = 0;
      n_compared = 0;
      rst = 1'b1;
      qv = 1'b0;
      q = '0;
      drv = '0;
      slow = 1'b0;
      awv = 1'b0;
      awa = 12'h0;
      wv = 1'b0;
      wd = 32'h0;
      ws = 4'h0;
      bready = 1'b0;
      arv = 1'b0;
      ara = 12'h0;
      rready = 1'b0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_causes();
      t_count_bcast();
      t_disable();
      stop_test();
   end
endmodule : modbus_exception_responder_bench
